//--- include/mpfm_regs.vh
// Register map, field positions and reset values of the pin function mux.
// Assumes inclusion by the single design file; definitions only.
`ifndef MPFM_REGS_VH
`define MPFM_REGS_VH

// Printed register indexes (byte address is four times the index)
`define MPFM_IDX_DATA_DIR     8'h19
`define MPFM_IDX_SEL_LOW      8'h1A
`define MPFM_IDX_SEL_HIGH     8'h1B
`define MPFM_IDX_INT_STATUS   8'h30
`define MPFM_IDX_INT_ENABLE   8'h31
`define MPFM_IDX_INT_CLEAR    8'h32

// Reset values
`define MPFM_RST_DATA_DIR     8'h01
`define MPFM_RST_SEL_LOW      8'h00
`define MPFM_RST_SEL_HIGH     8'h00

// Field positions
`define MPFM_DIR_LSB          0
`define MPFM_DATA_LSB         4

// Function selector codes
`define MPFM_SEL_SDO          4'h0
`define MPFM_SEL_FIFO_FULL    4'h1
`define MPFM_SEL_READ_DONE    4'h2
`define MPFM_SEL_FILT_RDY_N   4'h3
`define MPFM_SEL_HI_THR       4'h4
`define MPFM_SEL_LO_THR       4'h5
`define MPFM_SEL_ALERT_N      4'h6
`define MPFM_SEL_PIN_DATA     4'h7
`define MPFM_SEL_SYNC_IN_N    4'h8
`define MPFM_SEL_TRIG_IN      4'h9
`define MPFM_SEL_FORBIDDEN    4'hA

// AXI response codes
`define MPFM_RESP_OKAY        2'h0
`define MPFM_RESP_SLVERR      2'h2

`endif

//--- src/mpfm_top.v
// Four multipurpose pins: data/direction and function-select registers,
// output mux, input capture, interrupt on pin-in events, AXI4-Lite slave.
// Assumes one clock aclk; pin inputs are asynchronous and synchronised here.
// Internal source levels share aclk and are read without synchronisers.
// Host logic drives a pin only while pin_oe for it is low.
// Register bus answers one write and one read at a time.
// Byte address of each register is four times its index.
// Interrupt status, enable and clear sit at indexes 0x30 to 0x32.
// Pins at selectors 1010 and above stay undriven whatever their direction bit.
// Software must keep 1010 out of every selector field.
//
// Functional notes
// - Each pin has a data bit that sets its output level under selector 0111 and reads back its current level.
// - Each pin has a direction bit, 0 input with driver off, 1 output.
// - After reset pin 0 is an output and all other direction and data bits are 0.
// - The low selector register holds pin 1's selector in [7:4] and pin 0's in [3:0], reset 0.
// - The high selector register holds pin 3's selector in [7:4] and pin 2's in [3:0], reset 0.
// - Selector 0000 drives the pin from the configuration serial data output.
// - Selector 0001 drives the pin from the result FIFO full flag.
// - Selector 0010 drives the pin from the FIFO read-out done flag.
// - Selector 0011 drives the pin low while a filter result is ready.
// - Selector 0100 drives high-threshold detect, 0101 low-threshold detect.
// - Selector 0110 drives the pin low while the status alert is asserted.
// - Selector 0111 drives the pin from its own data bit.
// - Selector 1000 uses the pin as an active-low filter synchronisation input.
// - Selector 1001 uses the pin as an external FIFO event trigger input.
`timescale 1ns/100ps
`include "mpfm_regs.vh"

module mpfm_top (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Internal sources routed out to the pins
  input  wire        cfg_sdo,
  input  wire        fifo_full,
  input  wire        fifo_read_done,
  input  wire        filt_result_ready,
  input  wire        hi_thr_detect,
  input  wire        lo_thr_detect,
  input  wire        status_alert,
  // Functions fed from the pins
  output wire        filt_sync_n,
  output wire        fifo_ext_trigger,
  // Pins
  input  wire [3:0]  pin_in,
  output wire [3:0]  pin_out,
  output wire [3:0]  pin_oe,
  // Interrupt
  output wire        irq
);

  // Reset image of the data/direction register, split into fields below
  localparam [7:0] RST_DATA_DIR = `MPFM_RST_DATA_DIR;

  // Configuration and interrupt registers
  // Stored data bits drive selector 0111; reads show the pin level instead
  // Interrupt enable has one bit per pin, like status and clear
  reg  [3:0]  dir_ff;
  reg  [3:0]  data_ff;
  reg  [7:0]  sel_low_ff;
  reg  [7:0]  sel_high_ff;
  reg  [3:0]  int_status_ff;
  reg  [3:0]  int_enable_ff;
  reg  [3:0]  nxt_int_status;
  // Pin synchronisers and edge history
  reg  [3:0]  pin_meta_ff;
  reg  [3:0]  pin_sync_ff;
  reg  [3:0]  pin_prev_ff;
  // Pin outputs
  reg  [3:0]  pin_out_ff;
  reg  [3:0]  pin_oe_ff;
  reg         filt_sync_n_ff;
  reg         fifo_trig_ff;
  reg         irq_ff;
  // Bus handshake state
  reg         awready_ff;
  reg         wready_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg         arready_ff;
  reg         rvalid_ff;
  reg  [1:0]  rresp_ff;
  reg  [31:0] rdata_ff;
  reg  [31:0] awaddr_ff;
  reg         aw_held_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         w_held_ff;

  // Both selector registers as one vector, four bits per pin
  wire [15:0] sel_all = {sel_high_ff, sel_low_ff};
  wire [3:0]  pin_drive;
  wire [3:0]  pin_en;
  wire [3:0]  pin_sync_use;
  wire [3:0]  pin_trig_use;

  // Per-pin function mux
  // Selectors 0000 to 0111 name a source; anything else turns the driver off
  // Input functions need direction 0 so a pin never drives and listens at once
  // Sources are same-clock levels, registered once on the way out
  // Generated once per pin; pin n reads selector bits 4n+3 to 4n
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      wire [3:0] sel = sel_all[4*gi +: 4];
      reg        src;
      reg        drv;
      always @* begin
        src = 1'b0;
        drv = 1'b1;
        case (sel)
          `MPFM_SEL_SDO:        src = cfg_sdo;
          `MPFM_SEL_FIFO_FULL:  src = fifo_full;
          `MPFM_SEL_READ_DONE:  src = fifo_read_done;
          `MPFM_SEL_FILT_RDY_N: src = ~filt_result_ready;
          `MPFM_SEL_HI_THR:     src = hi_thr_detect;
          `MPFM_SEL_LO_THR:     src = lo_thr_detect;
          `MPFM_SEL_ALERT_N:    src = ~status_alert;
          `MPFM_SEL_PIN_DATA:   src = data_ff[gi];
          default:              drv = 1'b0;
        endcase
      end
      // Driver on only for an output pin with a source function
      assign pin_drive[gi]    = src;
      assign pin_en[gi]       = dir_ff[gi] & drv;
      assign pin_sync_use[gi] = (sel == `MPFM_SEL_SYNC_IN_N) & ~dir_ff[gi];
      assign pin_trig_use[gi] = (sel == `MPFM_SEL_TRIG_IN) & ~dir_ff[gi];
    end
  endgenerate

  // Pin synchroniser and output registers
  // Only pin_sync_ff reads pin_meta_ff; everything else sees synchronised levels
  // Input functions land three edges after a pin change
  // filt_sync_n idles high so no false sync pulse leaves reset
  // Pin outputs and driver enables are registered so pins never glitch
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff    <= 4'h0;
      pin_sync_ff    <= 4'h0;
      pin_prev_ff    <= 4'h0;
      pin_out_ff     <= 4'h0;
      pin_oe_ff      <= 4'h0;
      filt_sync_n_ff <= 1'b1;
      fifo_trig_ff   <= 1'b0;
    end else begin
      pin_meta_ff    <= pin_in;
      pin_sync_ff    <= pin_meta_ff;
      pin_prev_ff    <= pin_sync_ff;
      pin_out_ff     <= pin_drive;
      pin_oe_ff      <= pin_en;
      filt_sync_n_ff <= ~|(pin_sync_use & ~pin_sync_ff);
      fifo_trig_ff   <= |(pin_trig_use & pin_sync_ff);
    end
  end

  // Events: sync falling edge, trigger rising edge; set beats clear
  // Edge history resets low like the sync stage, so reset makes no edge
  // An edge counts only while the pin's selector and direction pick the input
  // A trigger pin counts rising edges, a sync pin falling edges
  wire [3:0] ev = (pin_sync_use & pin_prev_ff & ~pin_sync_ff) |
                  (pin_trig_use & ~pin_prev_ff & pin_sync_ff);

  // Write channel decode
  // Address and data are taken in either order and held until both are in
  // Held copies win over the bus so a released valid cannot change the target
  // Lane 0 carries all register bits; without it a write is answered but ignored
  // Unmapped indexes answer SLVERR and change nothing
  // do_wr waits for a free response slot so a second write cannot overrun it
  wire        aw_take = s_axi_awvalid & awready_ff;
  wire        w_take  = s_axi_wvalid & wready_ff;
  wire        aw_have = aw_held_ff | aw_take;
  wire        w_have  = w_held_ff | w_take;
  wire [31:0] wa      = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wd      = w_held_ff ? wdata_ff : s_axi_wdata;
  wire [3:0]  ws      = w_held_ff ? wstrb_ff : s_axi_wstrb;
  wire        do_wr   = aw_have & w_have & ~bvalid_ff;
  wire [29:0] widx    = wa[31:2];
  wire        wr_ok   = (widx == {22'h0, `MPFM_IDX_DATA_DIR}) |
                        (widx == {22'h0, `MPFM_IDX_SEL_LOW}) |
                        (widx == {22'h0, `MPFM_IDX_SEL_HIGH}) |
                        (widx == {22'h0, `MPFM_IDX_INT_ENABLE}) |
                        (widx == {22'h0, `MPFM_IDX_INT_CLEAR}) |
                        (widx == {22'h0, `MPFM_IDX_INT_STATUS});
  wire        wr_lane = do_wr & ws[0];
  wire [3:0]  clr     = (wr_lane && widx == {22'h0, `MPFM_IDX_INT_CLEAR}) ?
                        wd[3:0] : 4'h0;

  // Sticky status: a clear write drops bits, a new event in the same cycle stays
  // Status itself is read-only; a write to it is answered and ignored
  // Events are computed from synchronised levels only
  always @* begin
    nxt_int_status = (int_status_ff & ~clr) | ev;
  end

  // Write path and configuration registers
  // Ready drops on a take and returns only with the response handshake
  // irq follows the next status so it rises with the status bit itself
  // Reset values of the pin fields come from the register's reset image
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff    <= 1'b1;
      wready_ff     <= 1'b1;
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      awaddr_ff     <= 32'h0;
      wdata_ff      <= 32'h0;
      wstrb_ff      <= 4'h0;
      bvalid_ff     <= 1'b0;
      bresp_ff      <= `MPFM_RESP_OKAY;
      dir_ff        <= RST_DATA_DIR[`MPFM_DIR_LSB +: 4];
      data_ff       <= RST_DATA_DIR[`MPFM_DATA_LSB +: 4];
      sel_low_ff    <= `MPFM_RST_SEL_LOW;
      sel_high_ff   <= `MPFM_RST_SEL_HIGH;
      int_status_ff <= 4'h0;
      int_enable_ff <= 4'h0;
      irq_ff        <= 1'b0;
    end else begin
      int_status_ff <= nxt_int_status;
      irq_ff        <= |(nxt_int_status & int_enable_ff);
      // Address taken; held until the data is in
      if (aw_take) begin
        awaddr_ff  <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      // Data and strobes taken; held until the address is in
      if (w_take) begin
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      // Both halves in: apply, answer and release the holds
      if (do_wr) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_ok ? `MPFM_RESP_OKAY : `MPFM_RESP_SLVERR;
        if (wr_lane) begin
          case (widx)
            {22'h0, `MPFM_IDX_DATA_DIR}: begin
              dir_ff  <= wd[`MPFM_DIR_LSB +: 4];
              data_ff <= wd[`MPFM_DATA_LSB +: 4];
            end
            {22'h0, `MPFM_IDX_SEL_LOW}:   sel_low_ff    <= wd[7:0];
            {22'h0, `MPFM_IDX_SEL_HIGH}:  sel_high_ff   <= wd[7:0];
            {22'h0, `MPFM_IDX_INT_ENABLE}: int_enable_ff <= wd[3:0];
            default: ;
          endcase
        end
      end
      // Response accepted: open both channels again
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // Pin level readback: driven level while pin_oe is set, synchronised input else
  // Readback of an input pin lags the pin by the two synchroniser stages
  // Pins with pin_oe set read back the level they are being driven to
  wire [3:0] pin_level = (pin_oe_ff & pin_out_ff) | (~pin_oe_ff & pin_sync_ff);
  wire [29:0] ridx = s_axi_araddr[31:2];

  // Read path
  // Data is captured at the address take and held until rready
  // The clear register reads zero; unmapped indexes answer SLVERR with zero data
  // arready stays low while rvalid stands, so rdata cannot change under it
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `MPFM_RESP_OKAY;
      rdata_ff   <= 32'h0;
    end else begin
      if (s_axi_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rresp_ff   <= `MPFM_RESP_OKAY;
        case (ridx)
          {22'h0, `MPFM_IDX_DATA_DIR}:   rdata_ff <= {24'h0, pin_level, dir_ff};
          {22'h0, `MPFM_IDX_SEL_LOW}:    rdata_ff <= {24'h0, sel_low_ff};
          {22'h0, `MPFM_IDX_SEL_HIGH}:   rdata_ff <= {24'h0, sel_high_ff};
          {22'h0, `MPFM_IDX_INT_STATUS}: rdata_ff <= {28'h0, int_status_ff};
          {22'h0, `MPFM_IDX_INT_ENABLE}: rdata_ff <= {28'h0, int_enable_ff};
          {22'h0, `MPFM_IDX_INT_CLEAR}:  rdata_ff <= 32'h0;
          default: begin
            rdata_ff <= 32'h0;
            rresp_ff <= `MPFM_RESP_SLVERR;
          end
        endcase
      end
      // Data accepted: take the next address
      if (rvalid_ff && s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // Output assignments straight from flip-flops
  // No logic between these flip-flops and the pins keeps output timing clean
  // Bus outputs follow the handshake registers directly
  assign s_axi_awready    = awready_ff;
  assign s_axi_wready     = wready_ff;
  assign s_axi_bvalid     = bvalid_ff;
  assign s_axi_bresp      = bresp_ff;
  assign s_axi_arready    = arready_ff;
  assign s_axi_rvalid     = rvalid_ff;
  assign s_axi_rresp      = rresp_ff;
  assign s_axi_rdata      = rdata_ff;
  assign pin_out          = pin_out_ff;
  assign pin_oe           = pin_oe_ff;
  assign filt_sync_n      = filt_sync_n_ff;
  assign fifo_ext_trigger = fifo_trig_ff;
  assign irq              = irq_ff;

endmodule

//--- verification/mpfm_top_properties.sv
// Checker for the pin mux: bus handshakes, reset state and pin input timing.
// Assumes a bind to mpfm_top; sees its ports only.
`timescale 1ns/100ps
module mpfm_props (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus handshakes
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Pins and functions
  input wire        filt_sync_n,
  input wire        fifo_ext_trigger,
  input wire [3:0]  pin_in,
  input wire [3:0]  pin_oe,
  input wire        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers and holds
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write not answered");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  // Reset state of pins and interrupt
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && pin_oe == 4'h0)
    else $error("outputs active in reset");
  a_pin0_out: assert property ($rose(aresetn) |=> pin_oe == 4'h1)
    else $error("pin 0 not driven after reset");
  // Pin inputs reach their functions after three edges
  a_sync_cause: assert property (!filt_sync_n |-> $past(pin_in, 3) != 4'hF)
    else $error("sync low with no low pin");
  a_trig_cause: assert property (fifo_ext_trigger |-> $past(pin_in, 3) != 4'h0)
    else $error("trigger with no high pin");
  // Main scenarios
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(irq));
  c_sync: cover property (!filt_sync_n);
endmodule

bind mpfm_top mpfm_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .filt_sync_n,
  .fifo_ext_trigger, .pin_in, .pin_oe, .irq);

//--- verification/mpfm_host_model.sv
// Host logic on the four pins; resolves each pin from both drivers.
// Assumes the bench sets the host's levels.
`timescale 1ns/100ps
module mpfm_host_model (
  // From the device
  input  wire [3:0] pin_out,
  input  wire [3:0] pin_oe,
  // Host levels
  input  wire [3:0] host_lvl,
  // Back to the device
  output wire [3:0] pin_in
);
  // Device driver wins; host drives pins left as inputs
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & host_lvl);
endmodule

//--- verification/mpfm_top_tb.sv
// Self-checking bench for the pin mux over its register bus and pins.
// Assumes mpfm_top, the host model and the bound checker.
`timescale 1ns/100ps
module mpfm_top_tb;
  // Stimulus
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF, host_lvl = 4'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, done;
  reg  [6:0]  src = 7'h0;
  // Observed
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        filt_sync_n, fifo_ext_trigger, irq;
  wire [3:0]  pin_in, pin_out, pin_oe;
  integer     fails = 0, check_count = 0, n;

  mpfm_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_sdo(src[0]),
    .fifo_full(src[1]), .fifo_read_done(src[2]), .filt_result_ready(src[3]),
    .hi_thr_detect(src[4]), .lo_thr_detect(src[5]), .status_alert(src[6]),
    .filt_sync_n, .fifo_ext_trigger, .pin_in, .pin_out, .pin_oe, .irq);
  mpfm_host_model u_host (.pin_out, .pin_oe, .host_lvl, .pin_in);

  // 125 MHz clock
  always #4 aclk = ~aclk;

  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Compare one value
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  // One edge of a bounded wait
  task tick;
    begin
      @(posedge aclk);
      n = n + 1;
      if (n > 40) begin
        fails = fails + 1;
        close_out;
      end
    end
  endtask

  // Register write by index
  task wr(input [7:0] idx, input [7:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= {22'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      done = 1'b0;
      while (!done) begin
        tick;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          s_axi_bready <= 1'b0;
          chk(s_axi_bresp, (idx == 8'h1C) ? 32'h2 : 32'h0);
          done = 1'b1;
        end
      end
    end
  endtask

  // Register read by index, judged against exp and resp
  task rd(input [7:0] idx, input [31:0] exp, input [1:0] resp);
    begin
      @(posedge aclk);
      s_axi_araddr <= {22'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      done = 1'b0;
      while (!done) begin
        tick;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          s_axi_rready <= 1'b0;
          chk(s_axi_rdata, exp);
          chk(s_axi_rresp, resp);
          done = 1'b1;
        end
      end
    end
  endtask

  // Reset values and an unmapped place
  task t_reset;
    begin
      rd(8'h19, 32'h01, 2'h0);
      rd(8'h1A, 32'h00, 2'h0);
      rd(8'h1B, 32'h00, 2'h0);
      wr(8'h1C, 8'hFF);
      rd(8'h1C, 32'h00, 2'h2);
      $display("test reset done");
    end
  endtask

  // Each output selector against its own source, others opposite
  task t_drive;
    integer s, v;
    reg e;
    begin
      for (s = 0; s < 8; s = s + 1)
        for (v = 0; v < 2; v = v + 1) begin
          e = v[0] ^ (s == 3 || s == 6);
          src <= v[0] ? 7'h1 << s : ~(7'h1 << s);
          wr(8'h19, v[0] ? 8'hFF : 8'h0F);
          wr(8'h1A, {2{s[3:0]}});
          wr(8'h1B, {2{s[3:0]}});
          repeat (2) @(posedge aclk);
          chk(pin_oe, 32'hF);
          chk(pin_out, {28'h0, {4{e}}});
          rd(8'h19, {24'h0, {4{e}}, 4'hF}, 2'h0);
        end
      $display("test drive done");
    end
  endtask

  // Input functions and reserved selectors
  task t_input;
    begin
      wr(8'h19, 8'h08);
      wr(8'h1A, 8'h98);
      wr(8'h1B, 8'hFB);
      host_lvl <= 4'h2;
      repeat (5) @(posedge aclk);
      chk(pin_oe, 32'h0);
      chk(filt_sync_n, 32'h0);
      chk(fifo_ext_trigger, 32'h1);
      host_lvl <= 4'hD;
      repeat (5) @(posedge aclk);
      chk(filt_sync_n, 32'h1);
      chk(fifo_ext_trigger, 32'h0);
      $display("test input done");
    end
  endtask

  // Interrupt raised, masked, enabled and cleared
  task t_irq;
    begin
      wr(8'h32, 8'h0F);
      rd(8'h30, 32'h0, 2'h0);
      host_lvl <= 4'hE;
      repeat (5) @(posedge aclk);
      rd(8'h30, 32'h3, 2'h0);
      chk(irq, 32'h0);
      wr(8'h31, 8'h02);
      repeat (2) @(posedge aclk);
      chk(irq, 32'h1);
      wr(8'h32, 8'h02);
      repeat (2) @(posedge aclk);
      chk(irq, 32'h0);
      rd(8'h30, 32'h1, 2'h0);
      $display("test irq done");
    end
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_drive;
    t_input;
    t_irq;
    close_out;
  end
endmodule
